// >>> dv/can_engine_model.sv
// Behavioural CAN engine that stands for the bus and its other nodes
`timescale 1ns/100ps
`default_nettype none
module can_engine_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic txPending,
    input wire logic hold,
    input wire logic fail,
    output logic txStart,
    output logic txDone,
    output logic txFail
);
    logic [3:0] cnt_q;
    // Takes an offered frame unless stalled, then ends it eight cycles later
    always_ff @(posedge clock) begin
        txStart <= 1'b0;
        txDone <= 1'b0;
        txFail <= 1'b0;
        if (rst) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                txDone <= !fail;
                txFail <= fail;
            end
        end else if (txPending && !hold) begin
            txStart <= 1'b1;
            cnt_q <= 4'h8;
        end
    end
endmodule
`default_nettype wire

// >>> dv/can_tx_checker_sva.sv
// Port-level assertions for the mailbox transmit request block
`timescale 1ns/100ps
`default_nettype none
module can_tx_checker
    import tx_request_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [tx_request_pkg::BUS_WIDTH-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [tx_request_pkg::BUS_WIDTH-1:0] prdata,
    input wire logic txPending,
    input wire logic [3:0] txMailbox,
    input wire logic txStart,
    input wire logic txDone,
    input wire logic txFail
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire wr = psel && penable && pwrite && pstrb == 4'hF;
    wire rdSetup = psel && !penable && !pwrite;
    wire sending = !txPending && txMailbox != 4'h0;
    upper_zero_a: assert property (prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    req_reserved_a: assert property (rdSetup && paddr == OFF_REQUEST |=> prdata[8])
        else $error("request bit 8 not one");
    can_reserved_a: assert property (rdSetup && paddr == OFF_CANCEL |=> !prdata[8])
        else $error("cancel bit 8 not zero");
    offer_range_a: assert property (txPending |-> txMailbox != 4'h0)
        else $error("offer of mailbox zero");
    start_drop_a: assert property (txPending && txStart |=> !txPending && $stable(txMailbox))
        else $error("offer not taken cleanly");
    end_idle_a: assert property (sending && (txDone || txFail) |=> !txPending && txMailbox == 4'h0)
        else $error("no idle cycle after frame end");
    queue_offer_a: assert property (wr && paddr == OFF_REQUEST && pwdata[9] && txMailbox == 4'h0
        |=> ##[0:2] txPending && txMailbox == 4'h1)
        else $error("queued mailbox not offered");
    cancel_drop_a: assert property (wr && paddr == OFF_CANCEL && pwdata[0] && txPending && txMailbox == 4'h8
        && !txStart |-> ##[1:2] !txPending)
        else $error("cancel did not withdraw offer");
endmodule
bind can_mailbox_tx_request_cancel can_tx_checker can_tx_checker_inst (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .txPending(txPending), .txMailbox(txMailbox), .txStart(txStart), .txDone(txDone), .txFail(txFail));
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the mailbox transmit request and cancel block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import tx_request_pkg::*;
    logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0, fail = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'hF, txMailbox;
    logic pready, pslverr, txPending, txStart, txDone, txFail, irq, err;
    int n_mismatch = 0, checks = 0;
    can_mailbox_tx_request_cancel can_mailbox_tx_request_cancel_inst (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txPending(txPending), .txMailbox(txMailbox), .txStart(txStart),
        .txDone(txDone), .txFail(txFail), .irq(irq));
    can_engine_model can_engine_model_inst (.clock(clock), .rst(rst), .txPending(txPending), .hold(hold),
        .fail(fail), .txStart(txStart), .txDone(txDone), .txFail(txFail));
    initial forever #5 clock = ~clock;
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: bus transfer timed out", $time);
            conclude();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        xfer(a, 1'b0, 16'h0000);
        chk(rdat, {16'h0000, e});
    endtask
    // Polls a register until it shows the expected value
    task automatic poll(input logic [7:0] a, input logic [15:0] e);
        for (int i = 0; i < 40; i++) begin
            xfer(a, 1'b0, 16'h0000);
            if (rdat[15:0] === e) return;
        end
        n_mismatch++;
        $display("mismatch at %0t: poll timed out", $time);
        conclude();
    endtask
    task automatic waitHi(ref logic s);
        for (int i = 0; i < 40 && s !== 1'b1; i++) @(posedge clock);
        if (s !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: wait for signal timed out", $time);
            conclude();
        end
    endtask
    task automatic tReset;
        rdchk(OFF_REQUEST, 16'h0100);
        rdchk(OFF_CANCEL, 16'h0000);
        xfer(8'h40, 1'b0, 16'h0000);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask
    task automatic tRefuse;
        xfer(OFF_REQUEST, 1'b1, 16'h0100);
        xfer(OFF_CANCEL, 1'b1, 16'h0100);
        rdchk(OFF_REQUEST, 16'h0100);
        rdchk(OFF_CANCEL, 16'h0000);
        xfer(OFF_DIRECTION, 1'b1, 16'h0080);
        xfer(OFF_REQUEST, 1'b1, 16'h0080);
        rdchk(OFF_REQUEST, 16'h0100);
        xfer(OFF_DIRECTION, 1'b1, 16'h0000);
        $display("test refuse done");
    endtask
    task automatic tSend;
        xfer(OFF_TX_DONE_MASK, 1'b1, 16'hFFFF);
        fail <= 1'b1;
        xfer(OFF_REQUEST, 1'b1, 16'h0280);
        waitHi(txFail);
        fail <= 1'b0;
        chk({28'h0, txMailbox}, 32'h1);
        rdchk(OFF_REQUEST, 16'h0380);
        poll(OFF_REQUEST, 16'h0100);
        rdchk(OFF_TX_DONE, 16'h0280);
        chk({31'h0, irq}, 32'h1);
        xfer(OFF_TX_DONE, 1'b1, 16'h0280);
        rdchk(OFF_TX_DONE, 16'h0000);
        chk({31'h0, irq}, 32'h0);
        $display("test send done");
    endtask
    task automatic tCancel;
        hold <= 1'b1;
        xfer(OFF_ABORT_MASK, 1'b1, 16'h0001);
        xfer(OFF_REQUEST, 1'b1, 16'h0001);
        waitHi(txPending);
        chk({28'h0, txMailbox}, 32'h8);
        xfer(OFF_CANCEL, 1'b1, 16'h0001);
        poll(OFF_CANCEL, 16'h0000);
        rdchk(OFF_REQUEST, 16'h0100);
        rdchk(OFF_ABORT_DONE, 16'h0001);
        chk({31'h0, irq}, 32'h1);
        xfer(OFF_ABORT_DONE, 1'b1, 16'h0001);
        rdchk(OFF_ABORT_DONE, 16'h0000);
        chk({31'h0, irq}, 32'h0);
        hold <= 1'b0;
        $display("test cancel done");
    endtask
    task automatic tLate;
        xfer(OFF_REQUEST, 1'b1, 16'h0400);
        waitHi(txStart);
        xfer(OFF_CANCEL, 1'b1, 16'h0400);
        poll(OFF_REQUEST, 16'h0100);
        rdchk(OFF_TX_DONE, 16'h0400);
        rdchk(OFF_ABORT_DONE, 16'h0000);
        rdchk(OFF_CANCEL, 16'h0000);
        $display("test late cancel done");
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        tReset();
        tRefuse();
        tSend();
        tCancel();
        tLate();
        conclude();
    end
endmodule
`default_nettype wire

// >>> include/tx_request_pkg.sv
// Shared constants and types of the mailbox transmit request block
package tx_request_pkg;

    localparam int REG_WIDTH = 16;
    localparam int MB_COUNT = 15;
    localparam int RESERVED_BIT = 8;
    localparam int BUS_WIDTH = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_REQUEST = 8'h00;
    localparam logic [7:0] OFF_CANCEL = 8'h04;
    localparam logic [7:0] OFF_TX_DONE = 8'h08;
    localparam logic [7:0] OFF_ABORT_DONE = 8'h0C;
    localparam logic [7:0] OFF_DIRECTION = 8'h10;
    localparam logic [7:0] OFF_TX_DONE_MASK = 8'h14;
    localparam logic [7:0] OFF_ABORT_MASK = 8'h18;
    localparam logic [7:0] OFF_ENGINE_STATUS = 8'h1C;

    // Reset values
    localparam logic [15:0] RESET_REQUEST = 16'h0000;
    localparam logic [15:0] RESET_CANCEL = 16'h0000;
    localparam logic [15:0] RESET_FLAGS = 16'h0000;
    localparam logic [15:0] RESET_DIRECTION = 16'h0000;
    localparam logic [15:0] RESET_MASK = 16'h0000;

    // Fixed value of the reserved bit in request, cancel and flag reads
    localparam logic RESERVED_REQUEST_VALUE = 1'b1;
    localparam logic RESERVED_CANCEL_VALUE = 1'b0;
    localparam logic RESERVED_FLAG_VALUE = 1'b0;

    // Mailbox number of each register bit: bits 9..15 hold 1..7, bits 0..7 hold 8..15
    localparam logic [3:0] LOW_MB_BASE = 4'h8;
    localparam int HIGH_BIT_BASE = 9;

    // Engine status field positions
    localparam int STAT_MB_LSB = 0;
    localparam int STAT_STATE_LSB = 4;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_OFFER = 3'b010,
        ENG_SEND = 3'b100
    } engine_state_t;

    function automatic logic [3:0] bitToMailbox(input logic [3:0] b);
        if (b >= 4'(HIGH_BIT_BASE)) begin
            return b - LOW_MB_BASE;
        end
        return b + LOW_MB_BASE;
    endfunction

endpackage

// >>> verilog/can_mailbox_tx_request_cancel.sv
// Transmit request and cancel control for 15 mailboxes, APB slave with engine handshake
//
// Contract
// RULE_01: Writing 1 to a mailbox request bit queues that mailbox for transmission.
// RULE_02: A queued mailbox contends for the bus until sent or cancelled.
// RULE_03: Request bit clears itself on finished transmission or finished cancellation.
// RULE_04: Mailboxes 1..7 sit in bits 9..15, mailboxes 8..15 in bits 0..7.
// RULE_05: Bit 8 of request and cancel registers is read-only; writes ignored.
// RULE_06: Writing 1 to a cancel bit withdraws that mailbox's waiting frame.
// RULE_07: Cancel register uses the request bit mapping, no bit for mailbox 0.
// RULE_08: Cancel bit clears itself once cancellation has cleared the request bit.
// RULE_09: Software leaves direction bit 0 for transmit; 1 makes a receiver.
// RULE_10: Error-free transmission sets the mailbox transmit-done flag; write 1 clears.
// RULE_11: Error-free cancellation sets the mailbox abort-done flag; write 1 clears.
// RULE_12: Cancel acts only before the frame starts; a frame on the bus completes.
`timescale 1ns/100ps
`default_nettype none
module can_mailbox_tx_request_cancel (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [tx_request_pkg::BUS_WIDTH-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [tx_request_pkg::BUS_WIDTH-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txPending,
    output logic [3:0] txMailbox,
    input wire logic txStart,
    input wire logic txDone,
    input wire logic txFail,
    output logic irq
);
    import tx_request_pkg::*;

    // Bus phase decode
    wire setupPhase;
    wire writeAccess;
    wire lowLanes;
    assign setupPhase = psel & ~penable;
    assign writeAccess = psel & penable & pwrite;
    assign lowLanes = pstrb[0] & pstrb[1];

    wire hitRequest;
    wire hitCancel;
    wire hitTxDone;
    wire hitAbortDone;
    wire hitDirection;
    wire hitTxMask;
    wire hitAbortMask;
    wire hitStatus;
    wire hitAny;
    assign hitRequest = (paddr == OFF_REQUEST);
    assign hitCancel = (paddr == OFF_CANCEL);
    assign hitTxDone = (paddr == OFF_TX_DONE);
    assign hitAbortDone = (paddr == OFF_ABORT_DONE);
    assign hitDirection = (paddr == OFF_DIRECTION);
    assign hitTxMask = (paddr == OFF_TX_DONE_MASK);
    assign hitAbortMask = (paddr == OFF_ABORT_MASK);
    assign hitStatus = (paddr == OFF_ENGINE_STATUS);
    assign hitAny = hitRequest | hitCancel | hitTxDone | hitAbortDone | hitDirection
        | hitTxMask | hitAbortMask | hitStatus;

    // Write strobes per register, only the two low lanes carry the 16-bit value
    wire [15:0] wdata16;
    wire [15:0] wrOnes;
    wire wrRequest;
    wire wrCancel;
    wire wrTxDone;
    wire wrAbortDone;
    wire wrDirection;
    wire wrTxMask;
    wire wrAbortMask;
    assign wdata16 = pwdata[15:0];
    assign wrOnes = lowLanes ? wdata16 : 16'h0000;
    assign wrRequest = writeAccess & hitRequest;
    assign wrCancel = writeAccess & hitCancel;
    assign wrTxDone = writeAccess & hitTxDone;
    assign wrAbortDone = writeAccess & hitAbortDone;
    assign wrDirection = writeAccess & hitDirection & lowLanes;
    assign wrTxMask = writeAccess & hitTxMask & lowLanes;
    assign wrAbortMask = writeAccess & hitAbortMask & lowLanes;

    // Software-held registers
    logic [15:0] directionQ;
    logic [15:0] txMaskQ;
    logic [15:0] abortMaskQ;

    always_ff @(posedge clock) begin
        if (rst) begin
            directionQ <= RESET_DIRECTION;
            txMaskQ <= RESET_MASK;
            abortMaskQ <= RESET_MASK;
        end else begin
            if (wrDirection) begin
                directionQ <= wdata16;
            end
            if (wrTxMask) begin
                txMaskQ <= wdata16;
            end
            if (wrAbortMask) begin
                abortMaskQ <= wdata16;
            end
        end
    end

    // Per-mailbox state, indexed by register bit position
    logic [15:0] reqVec;
    logic [15:0] cancelVec;
    logic [15:0] txDoneVec;
    logic [15:0] abortDoneVec;
    logic [15:0] busyVec;
    logic [15:0] sentVec;

    // Transmit engine handshake state
    engine_state_t stateQ;
    engine_state_t stateD;
    logic [3:0] curBitQ;
    logic [3:0] curBitD;
    logic [15:0] curOneHot;
    logic [15:0] eligible;
    logic [3:0] pickBit;

    assign curOneHot = 16'h0001 << curBitQ;
    assign eligible = reqVec & ~cancelVec;

    // A frame taken by the engine this cycle is already past the point of cancel
    assign busyVec = ((stateQ == ENG_SEND) | ((stateQ == ENG_OFFER) & txStart)) ? curOneHot : 16'h0000; // RULE_12
    assign sentVec = ((stateQ == ENG_SEND) & txDone) ? curOneHot : 16'h0000;

    genvar b;
    generate
        for (b = 0; b < REG_WIDTH; b = b + 1) begin : gen_mb
            if (b == RESERVED_BIT) begin : gen_reserved
                // No mailbox here: bit stays constant and ignores writes
                assign reqVec[b] = RESERVED_REQUEST_VALUE; // RULE_05
                assign cancelVec[b] = RESERVED_CANCEL_VALUE; // RULE_05 RULE_07
                assign txDoneVec[b] = RESERVED_FLAG_VALUE;
                assign abortDoneVec[b] = RESERVED_FLAG_VALUE;
            end else begin : gen_slot
                mailbox_tx_slot slot (
                    .clock(clock),
                    .rst(rst),
                    .setReq(wrRequest & wrOnes[b]), // RULE_01 RULE_04
                    .setCancel(wrCancel & wrOnes[b]), // RULE_06 RULE_07
                    .clrTxDone(wrTxDone & wrOnes[b]),
                    .clrAbortDone(wrAbortDone & wrOnes[b]),
                    .isReceiver(directionQ[b]), // RULE_09
                    .busy(busyVec[b]),
                    .sentOk(sentVec[b]),
                    .reqQ(reqVec[b]),
                    .cancelQ(cancelVec[b]),
                    .txDoneQ(txDoneVec[b]),
                    .abortDoneQ(abortDoneVec[b])
                );
            end
        end
    endgenerate

    // Lowest mailbox number wins internal arbitration; reserved bit never picked
    always_comb begin
        pickBit = 4'h0;
        for (int m = MB_COUNT; m >= 1; m = m - 1) begin
            if (m < 8) begin
                if (eligible[m + 8]) begin
                    pickBit = 4'(m + 8);
                end
            end else begin
                if (eligible[m - 8]) begin
                    pickBit = 4'(m - 8);
                end
            end
        end
    end

    logic [15:0] eligibleTx;
    assign eligibleTx = eligible & ~(16'h0001 << RESERVED_BIT);

    always_comb begin
        stateD = stateQ;
        curBitD = curBitQ;
        case (stateQ)
            ENG_IDLE: begin
                if (|eligibleTx) begin
                    stateD = ENG_OFFER; // RULE_02
                    curBitD = pickBit;
                end
            end
            ENG_OFFER: begin
                if (txStart) begin
                    stateD = ENG_SEND;
                end else if (!eligibleTx[curBitQ]) begin
                    stateD = ENG_IDLE; // RULE_06
                end
            end
            ENG_SEND: begin
                if (txDone | txFail) begin
                    // A failed frame stays queued and contends again
                    stateD = ENG_IDLE; // RULE_02 RULE_03
                end
            end
            default: begin
                stateD = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            stateQ <= ENG_IDLE;
            curBitQ <= 4'h0;
        end else begin
            stateQ <= stateD;
            curBitQ <= curBitD;
        end
    end

    logic [3:0] txMailboxQ;
    always_ff @(posedge clock) begin
        if (rst) begin
            txMailboxQ <= 4'h0;
        end else begin
            txMailboxQ <= (stateD == ENG_IDLE) ? 4'h0 : bitToMailbox(curBitD);
        end
    end

    assign txPending = (stateQ == ENG_OFFER);
    assign txMailbox = txMailboxQ;

    // Interrupt: unmasked completion flags
    wire [15:0] irqBits;
    assign irqBits = (txDoneVec & txMaskQ) | (abortDoneVec & abortMaskQ);
    assign irq = |irqBits;

    // Read mux, captured in the setup cycle
    wire [15:0] statusWord;
    wire [15:0] readWord;
    assign statusWord = {9'h000, stateQ, txMailboxQ};
    assign readWord = hitRequest ? reqVec :
        hitCancel ? cancelVec :
        hitTxDone ? txDoneVec :
        hitAbortDone ? abortDoneVec :
        hitDirection ? directionQ :
        hitTxMask ? txMaskQ :
        hitAbortMask ? abortMaskQ :
        hitStatus ? statusWord : 16'h0000;

    logic [BUS_WIDTH-1:0] prdataQ;
    logic slvErrQ;
    always_ff @(posedge clock) begin
        if (rst) begin
            prdataQ <= 32'h00000000;
            slvErrQ <= 1'b0;
        end else if (setupPhase) begin
            prdataQ <= pwrite ? 32'h00000000 : {16'h0000, readWord};
            slvErrQ <= ~hitAny;
        end
    end

    assign prdata = prdataQ;
    assign pready = 1'b1;
    assign pslverr = psel & penable & slvErrQ;

endmodule
`default_nettype wire

// >>> verilog/mailbox_tx_slot.sv
// Per-mailbox request, cancel and completion flag state
`timescale 1ns/100ps
`default_nettype none
module mailbox_tx_slot (
    input wire logic clock,
    input wire logic rst,
    input wire logic setReq,
    input wire logic setCancel,
    input wire logic clrTxDone,
    input wire logic clrAbortDone,
    input wire logic isReceiver,
    input wire logic busy,
    input wire logic sentOk,
    output logic reqQ,
    output logic cancelQ,
    output logic txDoneQ,
    output logic abortDoneQ
);
    import tx_request_pkg::*;

    logic reqD;
    logic cancelD;
    logic txDoneD;
    logic abortDoneD;
    logic cancelNow;
    logic cancelIdle;
    logic acceptReq;

    // A mailbox set up as receiver does not queue a frame
    assign acceptReq = setReq & ~isReceiver; // RULE_01
    // Cancel only bites while the frame still waits for arbitration
    assign cancelNow = cancelQ & reqQ & ~busy; // RULE_06 RULE_12
    // Cancel with nothing queued has nothing to withdraw
    assign cancelIdle = cancelQ & ~reqQ;

    // Hardware clears on completion; a new software set in the same cycle wins
    assign reqD = acceptReq | (reqQ & ~(sentOk | cancelNow)); // RULE_02 RULE_03
    assign cancelD = setCancel | (cancelQ & ~(cancelNow | cancelIdle | sentOk)); // RULE_08
    assign txDoneD = sentOk | (txDoneQ & ~clrTxDone); // RULE_10
    assign abortDoneD = cancelNow | (abortDoneQ & ~clrAbortDone); // RULE_11

    always_ff @(posedge clock) begin
        if (rst) begin
            reqQ <= 1'b0;
            cancelQ <= 1'b0;
            txDoneQ <= 1'b0;
            abortDoneQ <= 1'b0;
        end else begin
            reqQ <= reqD;
            cancelQ <= cancelD;
            txDoneQ <= txDoneD;
            abortDoneQ <= abortDoneD;
        end
    end

endmodule
`default_nettype wire
